//--- verilog/dual_adc_serial_readout.sv
// serial readout and calibration sequencing of a dual 12-bit converter
// assumes the converter core delivers result pairs on clk and the host
// drives chip select, serial clock, serial input and the calibration pin
//
// Functional notes
// - 19 clocks converting, outputs high impedance
// - result bits change after falling edges
// - serial input sampled on falling edge
// - chip select rise releases both outputs
// - calibration pin high starts offset calibration
`timescale 1ns/100ps
module dual_adc_serial_readout #(
  parameter int POWERUP_INT_CYCLES = dual_adc_pkg::POWERUP_INT_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdin,
  input wire logic cal_pin,
  input wire logic ext_ref,
  input wire logic conv_valid,
  output logic conv_ready,
  input wire logic [11:0] conv_result_a,
  input wire logic [11:0] conv_result_b,
  output logic result_out_chan_a,
  output logic result_out_chan_a_oe,
  output logic result_out_chan_b,
  output logic result_out_chan_b_oe,
  output logic [31:0] cmd_word,
  output logic cmd_valid,
  output logic cal_start,
  output logic cal_active,
  output logic powerup_done
);
  // ------------------------------------------------------------
  // system clock side state
  // ------------------------------------------------------------
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic cal_s1;
    logic cal_s2;
    logic cal_s3;
    logic hold_valid;
    logic [11:0] hold_a;
    logic [11:0] hold_b;
    logic cal_start;
    logic cal_active;
    logic [31:0] cmd_word;
    logic cmd_valid;
    logic [15:0] pu_cnt;
    logic pu_done;
  } sys_state_t;

  // ------------------------------------------------------------
  // serial clock side state, cleared while chip select is high
  // ------------------------------------------------------------
  typedef struct packed {
    logic [5:0] cnt;
    logic [11:0] sh_a;
    logic [11:0] sh_b;
    logic out_a;
    logic out_b;
    logic oe;
  } link_state_t;

  localparam logic [15:0] PU_INT = 16'(POWERUP_INT_CYCLES);
  localparam logic [15:0] PU_EXT = 16'(dual_adc_pkg::POWERUP_EXT_CYCLES);

  sys_state_t sys_reg;
  sys_state_t sys_next;
  link_state_t link_reg;
  link_state_t link_next;
  logic [31:0] din_sh_reg;
  logic fifo_valid;
  logic fifo_pop;
  logic [23:0] fifo_data;
  logic cs_rise;

  result_fifo #(
    .WIDTH(dual_adc_pkg::WORD_BITS),
    .DEPTH(dual_adc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .in_data({conv_result_a, conv_result_b}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ------------------------------------------------------------
  // system side: pin sync, result hand-off, calibration, power-up
  // ------------------------------------------------------------
  always_comb begin
    sys_next = sys_reg;
    sys_next.cs_s1 = cs_n;
    sys_next.cs_s2 = sys_reg.cs_s1;
    sys_next.cs_s3 = sys_reg.cs_s2;
    sys_next.cal_s1 = cal_pin;
    sys_next.cal_s2 = sys_reg.cal_s1;
    sys_next.cal_s3 = sys_reg.cal_s2;
    cs_rise = sys_reg.cs_s2 && !sys_reg.cs_s3;
    // hold word is frozen while a frame runs; a frame end consumes it
    fifo_pop = sys_reg.cs_s2 && fifo_valid && (!sys_reg.hold_valid || cs_rise);
    if (cs_rise) begin
      sys_next.hold_valid = 1'b0;
    end
    if (fifo_pop) begin
      sys_next.hold_valid = 1'b1;
      sys_next.hold_a = fifo_data[23:12];
      sys_next.hold_b = fifo_data[11:0];
    end
    // serial input word is static once chip select is high
    sys_next.cmd_valid = cs_rise;
    if (cs_rise) begin
      sys_next.cmd_word = din_sh_reg;
    end
    sys_next.cal_start = sys_reg.cal_s2 && !sys_reg.cal_s3;
    sys_next.cal_active = sys_reg.cal_s2;
    if (!sys_reg.pu_done) begin
      sys_next.pu_cnt = sys_reg.pu_cnt + 16'h0001;
      sys_next.pu_done = (sys_next.pu_cnt >= (ext_ref ? PU_EXT : PU_INT));
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sys_reg <= '0;
      sys_reg.cs_s1 <= 1'b1;
      sys_reg.cs_s2 <= 1'b1;
      sys_reg.cs_s3 <= 1'b1;
    end else begin
      sys_reg <= sys_next;
    end
  end

  // ------------------------------------------------------------
  // link side: conversion count and result shifting
  // ------------------------------------------------------------
  always_comb begin
    link_next = link_reg;
    if (link_reg.cnt != dual_adc_pkg::CNT_MAX) begin
      link_next.cnt = link_reg.cnt + 6'h01;
    end
    if (link_next.cnt == dual_adc_pkg::CONV_EDGES) begin
      link_next.oe = 1'b1;
      link_next.out_a = sys_reg.hold_valid ? sys_reg.hold_a[11] : 1'b0;
      link_next.out_b = sys_reg.hold_valid ? sys_reg.hold_b[11] : 1'b0;
      link_next.sh_a = sys_reg.hold_valid ? {sys_reg.hold_a[10:0], 1'b0} : 12'h000;
      link_next.sh_b = sys_reg.hold_valid ? {sys_reg.hold_b[10:0], 1'b0} : 12'h000;
    end else if (link_next.cnt > dual_adc_pkg::CONV_EDGES && link_next.cnt < dual_adc_pkg::FRAME_EDGES) begin
      link_next.out_a = link_reg.sh_a[11];
      link_next.out_b = link_reg.sh_b[11];
      link_next.sh_a = {link_reg.sh_a[10:0], 1'b0};
      link_next.sh_b = {link_reg.sh_b[10:0], 1'b0};
    end else if (link_next.cnt == dual_adc_pkg::FRAME_EDGES) begin
      link_next.oe = 1'b0;
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  always_ff @(negedge sclk) begin
    if (!cs_n) begin
      din_sh_reg <= {din_sh_reg[30:0], sdin};
    end
  end

  assign result_out_chan_a = link_reg.out_a;
  assign result_out_chan_b = link_reg.out_b;
  assign result_out_chan_a_oe = link_reg.oe;
  assign result_out_chan_b_oe = link_reg.oe;
  assign cmd_word = sys_reg.cmd_word;
  assign cmd_valid = sys_reg.cmd_valid;
  assign cal_start = sys_reg.cal_start;
  assign cal_active = sys_reg.cal_active;
  assign powerup_done = sys_reg.pu_done;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_conv_done;
    link_reg.cnt == 6'h12 ##1 link_reg.cnt == 6'h13;
  endsequence

  sequence s_shift_step;
    link_reg.cnt >= 6'h13 && link_reg.cnt < 6'h1E;
  endsequence

  property p_hiz_conv;
    @(negedge sclk) disable iff (cs_n) $rose(link_reg.oe) |-> link_reg.cnt == 6'h13;
  endproperty
  a_hiz_conv: assert property (p_hiz_conv) else $error("outputs driven before conversion end");

  property p_drive_after;
    @(negedge sclk) disable iff (cs_n) s_conv_done |-> link_reg.oe;
  endproperty
  a_drive_after: assert property (p_drive_after) else $error("outputs not driven after conversion");

  property p_shift;
    @(negedge sclk) disable iff (cs_n) s_shift_step |=>
      result_out_chan_a == $past(link_reg.sh_a[11]) && result_out_chan_b == $past(link_reg.sh_b[11]);
  endproperty
  a_shift: assert property (p_shift) else $error("result bit not shifted on falling edge");

  property p_release;
    @(negedge sclk) disable iff (cs_n) link_reg.cnt == 6'h1E |=> !link_reg.oe [*2];
  endproperty
  a_release: assert property (p_release) else $error("outputs still driven after last bit");

  property p_sdin;
    @(negedge sclk) disable iff (cs_n) !$past(cs_n) |-> din_sh_reg[0] == $past(sdin);
  endproperty
  a_sdin: assert property (p_sdin) else $error("serial input not sampled");

  property p_cs_hiz;
    @(posedge clk) disable iff (reset) sys_reg.cs_s2 |-> !result_out_chan_a_oe && !result_out_chan_b_oe;
  endproperty
  a_cs_hiz: assert property (p_cs_hiz) else $error("outputs driven with chip select high");

  property p_cal;
    @(posedge clk) disable iff (reset) $rose(sys_reg.cal_s2) |=> cal_start ##1 (!cal_start && cal_active);
  endproperty
  a_cal: assert property (p_cal) else $error("calibration not started by pin");

  property p_same_oe;
    @(negedge sclk) disable iff (cs_n) result_out_chan_a_oe == result_out_chan_b_oe &&
      result_out_chan_a_oe == (link_reg.cnt >= dual_adc_pkg::CONV_EDGES && link_reg.cnt < dual_adc_pkg::FRAME_EDGES);
  endproperty
  a_same_oe: assert property (p_same_oe) else $error("channel outputs not driven together in the bit window");
endmodule // dual_adc_serial_readout

//--- common/dual_adc_pkg.sv
// constants shared by the serial readout block and its buffer
// assumes a 100 MHz system clock and a separate serial clock at the pins
package dual_adc_pkg;
  localparam int RESULT_BITS = 12;
  localparam int WORD_BITS = 2 * RESULT_BITS;
  localparam int FIFO_DEPTH = 4;
  localparam int DIN_BITS = 32;
  localparam int CNT_BITS = 6;
  // ------------------------------------------------------------
  // frame sequencing in serial clock falling edges
  // ------------------------------------------------------------
  localparam logic [5:0] CONV_EDGES = 6'h13;
  localparam logic [5:0] LAST_BIT_EDGE = 6'h1E;
  localparam logic [5:0] FRAME_EDGES = 6'h1F;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  // ------------------------------------------------------------
  // times and their counts at the system clock
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int QUIET_NS = 13;
  localparam int QUIET_CYCLES = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_HIGH_US = 2;
  localparam int CAL_HIGH_CYCLES = (CAL_HIGH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_TO_CS_US = 2;
  localparam int CAL_TO_CS_CYCLES = (CAL_TO_CS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_INT_US = 240;
  localparam int POWERUP_INT_CYCLES = (POWERUP_INT_US * 1000) / CLK_PERIOD_NS;
  localparam int POWERUP_EXT_US = 15;
  localparam int POWERUP_EXT_CYCLES = (POWERUP_EXT_US * 1000) / CLK_PERIOD_NS;
  localparam int PU_BITS = 16;
endpackage

//--- verilog/result_fifo.sv
// small first-in first-out buffer for conversion result words
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module result_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic push;
  logic pop;

  always_comb begin
    st_next = st_reg;
    push = in_valid && st_reg.rdy;
    pop = out_ready && (st_reg.cnt != '0);
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = (st_reg.wp == LAST) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = (st_reg.rp == LAST) ? '0 : st_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
    st_next.rdy = (st_next.cnt != FULL);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.rdy <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign in_ready = st_reg.rdy;
  assign out_valid = (st_reg.cnt != '0);
  assign out_data = st_reg.mem[st_reg.rp];
endmodule // result_fifo

//--- testbench/host_model.sv
// host serial controller model: chip select, link clock, serial input
// assumes the readout block drives result bits after falling link edges
`timescale 1ns/100ps
module host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdin,
  input wire logic res_a,
  input wire logic res_b,
  input wire logic oe_a,
  input wire logic oe_b
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdin = 1'b0;
  end
  // ------------------------------------------------------------
  // one frame of n falling edges, link clock still outside it
  // ------------------------------------------------------------
  // frames carry n clocks
  task automatic frame(input int n, input logic [31:0] cmd, output logic [23:0] word, output int bad);
    bad = 0;
    word = 24'h000000;
    cs_n = 1'b0;
    #16;
    for (int e = 1; e <= n; e++) begin
      sdin = cmd[n-e];
      #16 sclk = 1'b0;
      #16 sclk = 1'b1;
      if (((e >= 19) && (e <= 30)) !== (oe_a && oe_b) || oe_a !== oe_b) bad++;
      if (oe_a === 1'b1) word = {word[22:12], res_a, word[10:0], res_b};
    end
    cs_n = 1'b1;
    sdin = ~sdin;
    #1;
    if (oe_a !== 1'b0 || oe_b !== 1'b0) bad++;
    #99;
  endtask
endmodule // host_model

//--- testbench/dual_adc_serial_readout_tb.sv
// self-checking bench for the dual converter serial readout
// assumes the host model drives the link at a 32 ns period
`timescale 1ns/100ps
module dual_adc_serial_readout_tb;
  logic clk, reset, sclk, cs_n, sdin, cal_pin, ext_ref, conv_valid, conv_ready;
  logic out_a, oe_a, out_b, oe_b, cmd_valid, cal_start, cal_active, powerup_done;
  logic [11:0] res_a, res_b;
  logic [31:0] cmd_word, last_cmd;
  logic [23:0] word;
  int errors = 0, check_count = 0, cycles = 0, cal_pulses = 0, bad, n;
  typedef struct packed {logic [23:0] w; logic [31:0] cmd;} row_t;
  row_t rows [4] = '{'{24'hFFF000, 32'h80000001}, '{24'h000FFF, 32'hFFFFFFFF},
                     '{24'hA5C3A5, 32'h12345678}, '{24'h801001, 32'h00000000}};
  dual_adc_serial_readout #(.POWERUP_INT_CYCLES(50)) i_dual_adc_serial_readout (.clk(clk), .reset(reset),
    .sclk(sclk), .cs_n(cs_n), .sdin(sdin), .cal_pin(cal_pin), .ext_ref(ext_ref), .conv_valid(conv_valid),
    .conv_ready(conv_ready), .conv_result_a(res_a), .conv_result_b(res_b), .result_out_chan_a(out_a),
    .result_out_chan_a_oe(oe_a), .result_out_chan_b(out_b), .result_out_chan_b_oe(oe_b),
    .cmd_word(cmd_word), .cmd_valid(cmd_valid), .cal_start(cal_start), .cal_active(cal_active),
    .powerup_done(powerup_done));
  host_model i_host_model (.sclk(sclk), .cs_n(cs_n), .sdin(sdin), .res_a(out_a), .res_b(out_b),
    .oe_a(oe_a), .oe_b(oe_b));
  // ------------------------------------------------------------
  // clock, monitors and tasks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cmd_valid === 1'b1) last_cmd <= cmd_word;
    if (cal_start === 1'b1) cal_pulses++;
    if (cycles == 30000) begin
      errors++;
      end_sim;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic push(input logic [23:0] w);
    @(negedge clk);
    {res_a, res_b} = w;
    conv_valid = 1'b1;
    @(negedge clk);
    conv_valid = 1'b0;
  endtask
  task automatic xfer(input int edges, input logic [31:0] cmd, input logic [23:0] w);
    i_host_model.frame(edges, cmd, word, bad);
    chk(bad, 0);
    chk(word, w);
  endtask
  task automatic do_reset(input logic ext, input int exp);
    @(negedge clk);
    reset = 1'b1;
    ext_ref = ext;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    n = 0;
    while (powerup_done !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk(n >= exp - 3 && n <= exp + 3, 1);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    cal_pin = 1'b0;
    ext_ref = 1'b0;
    conv_valid = 1'b0;
    {res_a, res_b} = 24'h000000;
    do_reset(1'b0, 50);
    foreach (rows[i]) begin
      push(rows[i].w);
      xfer(32, rows[i].cmd, rows[i].w);
      chk(last_cmd, rows[i].cmd);
    end
    push(24'h123456);
    push(24'hFC0FC0);
    push(24'hABCDEF);
    xfer(10, 32'h000003FF, 24'h000000);
    xfer(25, 32'h01FFFFFF, 24'h07E07E);
    xfer(32, 32'h0, 24'hABCDEF);
    n = 0;
    for (int k = 1; k <= 8; k++) begin
      @(negedge clk);
      if (conv_ready === 1'b1) n++;
      {res_a, res_b} = {k[11:0], ~k[11:0]};
      conv_valid = 1'b1;
    end
    @(negedge clk);
    conv_valid = 1'b0;
    chk(conv_ready, 0);
    for (int k = 1; k <= n; k++) xfer(32, 32'h0, {k[11:0], ~k[11:0]});
    xfer(32, 32'h0, 24'h000000);
    // pin held 2.1 us before select
    @(negedge clk);
    cal_pin = 1'b1;
    repeat (210) @(negedge clk);
    chk(cal_active, 1);
    chk(cal_pulses, 1);
    cal_pin = 1'b0;
    repeat (5) @(negedge clk);
    chk(cal_active, 0);
    push(24'h5A5A5A);
    do_reset(1'b1, 1500);
    xfer(32, 32'h0, 24'h000000);
    end_sim;
  end
endmodule // dual_adc_serial_readout_tb
